// ===== rtl/fpc_consts.svh
// constants of the flash protection controller
`ifndef FPC_CONSTS_SVH
`define FPC_CONSTS_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define FPC_OFF_ADDR  12'h000
`define FPC_OFF_DATA  12'h004
`define FPC_OFF_CTRL  12'h008
`define FPC_OFF_RAW   12'h00c
`define FPC_OFF_MASK  12'h010
`define FPC_OFF_MCLR  12'h014
`define FPC_OFF_RDEN  12'h130
`define FPC_OFF_PGEN  12'h134
`define FPC_OFF_USEC  12'h140

// ------------------------------------------------------------
// reset values and fields
// ------------------------------------------------------------
`define FPC_RDEN_RST  32'hbfffffff
`define FPC_PGEN_RST  32'hffffffff
`define FPC_USEC_RST  8'h31
`define FPC_KEY       16'ha442
`define FPC_C_WRITE   0
`define FPC_C_ERASE   1
`define FPC_C_MERASE  2
`define FPC_C_COMMIT  3
`define FPC_DBG_ON    2'h2
`define FPC_DBG_ADDR  32'h00000900
`define FPC_ST_ACC    0
`define FPC_ST_PRG    1
`define FPC_RD_REGS   30

// ------------------------------------------------------------
// array geometry and timing
// ------------------------------------------------------------
`define FPC_AW        14
`define FPC_WORDS     16384
`define FPC_PROG_US   16
`define FPC_ERASE_US  1000
`define FPC_MASS_US   10000
`define FPC_COMMIT_US 16

`endif

// ===== rtl/fpc_pkg.sv
// types of the flash protection controller
package fpc_pkg;
`include "fpc_consts.svh"

   typedef enum logic [2:0] {ST_LOAD, ST_IDLE, ST_WAIT, ST_RMW, ST_FILL, ST_COMMIT} fpc_state_t;
   typedef enum logic [2:0] {OP_NONE, OP_PROG, OP_ERASE, OP_MASS, OP_COMMIT} fpc_op_t;

   typedef struct packed {
      logic [`FPC_AW-1:0] addr;
      logic               fetch;
      logic               debug;
   } fpc_rd_req_t;

   typedef struct packed {
      logic [31:0] rdata;
      logic        ready;
      logic        fault;
   } fpc_rd_rsp_t;
endpackage

// ===== rtl/fpc_mem.sv
// flash word array with registered read data
`timescale 1ns/1ps
`include "fpc_consts.svh"
module fpc_mem
   import fpc_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic              we,
   input  wire logic [`FPC_AW-1:0] addr,
   input  wire logic [31:0]       wdata,
   output logic      [31:0]       rdata
);
   logic [31:0] mem [`FPC_WORDS];

   always_ff @(posedge clk_sys)
   begin
      if (we)
      begin
         mem[addr] <= wdata;
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         rdata <= 32'h00000000;
      end
      else
      begin
         rdata <= mem[addr];
      end
   end
endmodule // fpc_mem

// ===== rtl/fpc_ctrl.sv
// flash controller with protection, commit and status logic
`timescale 1ns/1ps
`include "fpc_consts.svh"
module fpc_ctrl
   import fpc_pkg::*;
#(
   parameter int unsigned PROG_US   = `FPC_PROG_US,
   parameter int unsigned ERASE_US  = `FPC_ERASE_US,
   parameter int unsigned MASS_US   = `FPC_MASS_US,
   parameter int unsigned COMMIT_US = `FPC_COMMIT_US
)
(
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        rst_factory,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        rd_valid,
   input  wire fpc_rd_req_t rd_req,
   output fpc_rd_rsp_t      rd_rsp,
   output logic             flash_irq,
   output logic             dap_enable,
   output logic             busy
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [31:0]        addr_q, addr_d;
   logic [31:0]        data_q, data_d;
   logic [3:0]         cmd_q, cmd_d;
   logic [1:0]         im_q, im_d;
   logic [1:0]         ris_q, ris_d;
   logic [31:0]        pre_q, pre_d;
   logic [31:0]        ppe_q, ppe_d;
   logic [7:0]         usec_q, usec_d;
   logic [31:0]        nv_pre_q, nv_pre_d;
   logic [31:0]        nv_ppe_q, nv_ppe_d;
   logic               dap_q, dap_d;
   fpc_state_t         state_q, state_d;
   fpc_op_t            op_q, op_d;
   logic [7:0]         tick_q, tick_d;
   logic [19:0]        us_q, us_d;
   logic [`FPC_AW-1:0] fill_q, fill_d;
   logic               ack_q, ack_d;
   logic               fault_q, fault_d;

   logic               mem_we;
   logic [`FPC_AW-1:0] mem_addr;
   logic [31:0]        mem_wdata;
   logic [31:0]        mem_rdata;

   logic               wr, hit, tick, key_ok, rd_ok, deny;
   logic [4:0]         pg_region, rd_region;
   logic               set_acc, set_prg;

   fpc_mem u_mem (
      .clk_sys (clk_sys),
      .rst     (rst),
      .we      (mem_we),
      .addr    (mem_addr),
      .wdata   (mem_wdata),
      .rdata   (mem_rdata)
   );

   // ------------------------------------------------------------
   // bus decode and read mux
   // ------------------------------------------------------------
   assign wr     = psel & penable & pwrite;
   assign pready = 1'b1;
   assign key_ok = pwdata[31:16] == `FPC_KEY;

   always_comb
   begin
      hit    = 1'b1;
      prdata = 32'h00000000;
      case (paddr)
         `FPC_OFF_ADDR: prdata = addr_q;
         `FPC_OFF_DATA: prdata = data_q;
         `FPC_OFF_CTRL: prdata = {28'h0000000, cmd_q};
         `FPC_OFF_RAW:  prdata = {30'h00000000, ris_q};
         `FPC_OFF_MASK: prdata = {30'h00000000, im_q};
         `FPC_OFF_MCLR: prdata = {30'h00000000, ris_q & im_q};
         `FPC_OFF_RDEN: prdata = pre_q;
         `FPC_OFF_PGEN: prdata = ppe_q;
         `FPC_OFF_USEC: prdata = {24'h000000, usec_q};
         default:       hit    = 1'b0;
      endcase
   end

   assign pslverr = psel & penable & ~hit;

   // ------------------------------------------------------------
   // microsecond tick
   // ------------------------------------------------------------
   assign tick = tick_q == 8'h00;

   // ------------------------------------------------------------
   // read permission
   // ------------------------------------------------------------
   assign rd_region = rd_req.addr[`FPC_AW-1:`FPC_AW-5];
   assign pg_region = addr_q[15:11];
   assign rd_ok     = (rd_region >= 5'(`FPC_RD_REGS)) | pre_q[rd_region];
   assign deny      = (~rd_req.fetch & ~rd_ok) | (rd_req.debug & ~dap_q);

   // ------------------------------------------------------------
   // registers and operation sequencer
   // ------------------------------------------------------------
   always_comb
   begin
      addr_d    = addr_q;
      data_d    = data_q;
      cmd_d     = cmd_q;
      im_d      = im_q;
      pre_d     = pre_q;
      ppe_d     = ppe_q;
      usec_d    = usec_q;
      nv_pre_d  = nv_pre_q;
      nv_ppe_d  = nv_ppe_q;
      dap_d     = dap_q;
      state_d   = state_q;
      op_d      = op_q;
      us_d      = us_q;
      fill_d    = fill_q;
      ack_d     = 1'b0;
      fault_d   = 1'b0;
      mem_we    = 1'b0;
      mem_addr  = rd_req.addr;
      mem_wdata = 32'hffffffff;
      set_acc   = 1'b0;
      set_prg   = 1'b0;
      ris_d     = ris_q;
      tick_d    = tick ? usec_q : tick_q - 8'h01;
      if (wr)
      begin
         case (paddr)
            `FPC_OFF_ADDR: addr_d = pwdata;
            `FPC_OFF_DATA: data_d = pwdata;
            `FPC_OFF_MASK: im_d   = pwdata[1:0];
            `FPC_OFF_MCLR: ris_d  = ris_q & ~pwdata[1:0];
            `FPC_OFF_RDEN: pre_d  = pre_q & pwdata;
            `FPC_OFF_PGEN: ppe_d  = ppe_q & pwdata;
            `FPC_OFF_USEC: usec_d = pwdata[7:0];
            default: ;
         endcase
      end

      case (state_q)
         ST_LOAD:
         begin
            pre_d   = nv_pre_q;
            ppe_d   = nv_ppe_q;
            dap_d   = nv_pre_q[31:30] == `FPC_DBG_ON;
            state_d = ST_IDLE;
         end
         ST_IDLE:
         begin
            if (rd_valid && !ack_q)
            begin
               ack_d   = 1'b1;
               fault_d = deny;
            end
            if (wr && paddr == `FPC_OFF_CTRL && key_ok)
            begin
               if (pwdata[`FPC_C_COMMIT])
               begin
                  cmd_d   = 4'h8;
                  op_d    = OP_COMMIT;
                  us_d    = 20'(COMMIT_US);
                  state_d = ST_WAIT;
               end
               else if (pwdata[`FPC_C_MERASE])
               begin
                  if (&ppe_q)
                  begin
                     cmd_d   = 4'h4;
                     op_d    = OP_MASS;
                     us_d    = 20'(MASS_US);
                     state_d = ST_WAIT;
                  end
                  else
                     set_acc = 1'b1;
               end
               else if (pwdata[`FPC_C_ERASE] || pwdata[`FPC_C_WRITE])
               begin
                  if (ppe_q[pg_region])
                  begin
                     cmd_d   = pwdata[`FPC_C_ERASE] ? 4'h2 : 4'h1;
                     op_d    = pwdata[`FPC_C_ERASE] ? OP_ERASE : OP_PROG;
                     us_d    = pwdata[`FPC_C_ERASE] ? 20'(ERASE_US) : 20'(PROG_US);
                     state_d = ST_WAIT;
                  end
                  else
                     set_acc = 1'b1;
               end
            end
         end
         ST_WAIT:
         begin
            if (us_q == 20'h00000)
            begin
               case (op_q)
                  OP_PROG:
                  begin
                     mem_addr = addr_q[15:2];
                     state_d  = ST_RMW;
                  end
                  OP_ERASE:
                  begin
                     fill_d  = {addr_q[15:10], 8'h00};
                     state_d = ST_FILL;
                  end
                  OP_MASS:
                  begin
                     fill_d  = '0;
                     state_d = ST_FILL;
                  end
                  default: state_d = ST_COMMIT;
               endcase
            end
            else if (tick)
               us_d = us_q - 20'h00001;
         end
         ST_RMW:
         begin
            mem_we    = 1'b1;
            mem_addr  = addr_q[15:2];
            mem_wdata = mem_rdata & data_q;
            cmd_d     = 4'h0;
            set_prg   = 1'b1;
            state_d   = ST_IDLE;
         end
         ST_FILL:
         begin
            mem_we   = 1'b1;
            mem_addr = fill_q;
            fill_d   = fill_q + 1'b1;
            if ((op_q == OP_MASS) ? &fill_q : &fill_q[7:0])
            begin
               cmd_d   = 4'h0;
               set_prg = 1'b1;
               state_d = ST_IDLE;
            end
         end
         ST_COMMIT:
         begin
            if (addr_q == `FPC_DBG_ADDR)
               nv_pre_d = nv_pre_q & pre_q;
            else if (addr_q[0])
               nv_ppe_d = nv_ppe_q & ppe_q;
            else
               nv_pre_d = nv_pre_q & {2'b11, pre_q[29:0]};
            cmd_d   = 4'h0;
            state_d = ST_IDLE;
         end
         default: state_d = ST_IDLE;
      endcase

      ris_d[`FPC_ST_ACC] = ris_d[`FPC_ST_ACC] | set_acc;
      ris_d[`FPC_ST_PRG] = ris_d[`FPC_ST_PRG] | set_prg;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         addr_q  <= 32'h00000000;
         data_q  <= 32'h00000000;
         cmd_q   <= 4'h0;
         im_q    <= 2'h0;
         ris_q   <= 2'h0;
         pre_q   <= 32'h00000000;
         ppe_q   <= 32'h00000000;
         usec_q  <= `FPC_USEC_RST;
         dap_q   <= 1'b0;
         state_q <= ST_LOAD;
         op_q    <= OP_NONE;
         us_q    <= 20'h00000;
         fill_q  <= '0;
         ack_q   <= 1'b0;
         fault_q <= 1'b0;
         tick_q  <= `FPC_USEC_RST;
      end
      else
      begin
         addr_q  <= addr_d;
         data_q  <= data_d;
         cmd_q   <= cmd_d;
         im_q    <= im_d;
         ris_q   <= ris_d;
         pre_q   <= pre_d;
         ppe_q   <= ppe_d;
         usec_q  <= usec_d;
         dap_q   <= dap_d;
         state_q <= state_d;
         op_q    <= op_d;
         us_q    <= us_d;
         fill_q  <= fill_d;
         ack_q   <= ack_d;
         fault_q <= fault_d;
         tick_q  <= tick_d;
      end
   end

   // nonvolatile committed copies survive every reset but the factory one
   always_ff @(posedge clk_sys or posedge rst_factory)
   begin
      if (rst_factory)
      begin
         nv_pre_q <= `FPC_RDEN_RST;
         nv_ppe_q <= `FPC_PGEN_RST;
      end
      else
      begin
         nv_pre_q <= nv_pre_d;
         nv_ppe_q <= nv_ppe_d;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign rd_rsp.ready = ack_q;
   assign rd_rsp.fault = fault_q;
   assign rd_rsp.rdata = fault_q ? 32'h00000000 : mem_rdata;
   assign flash_irq    = |(ris_q & im_q);
   // only the debug port is gated; the test access port has no gate here
   assign dap_enable   = dap_q;
   assign busy         = state_q != ST_IDLE;
endmodule // fpc_ctrl

// ===== dv/fpc_ctrl_asserts.sv
// port assertions of the flash protection controller
`timescale 1ns/1ps
module fpc_ctrl_asserts
   import fpc_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        rd_valid,
   input wire fpc_rd_req_t rd_req,
   input wire fpc_rd_rsp_t rd_rsp,
   input wire logic        flash_irq,
   input wire logic        dap_enable,
   input wire logic        busy
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic acc;
   logic mapped;
   assign acc    = psel && penable;
   assign mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014,
                                 12'h130, 12'h134, 12'h140};

   sequence commit_wr;
      acc && pwrite && paddr == 12'h008 && pwdata[31:16] == 16'ha442 && pwdata[3] && !busy;
   endsequence
   sequence rd_take;
      rd_valid && !busy && !rd_rsp.ready;
   endsequence

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   unmapped_fault_a: assert property (acc |-> pslverr == !mapped)
      else $error("slave error does not follow the offset decode");
   read_latency_a: assert property (rd_take |=> rd_rsp.ready)
      else $error("flash read not answered one cycle after it was taken");
   read_stall_a: assert property (rd_rsp.ready |-> !$past(busy) && !$past(rd_rsp.ready))
      else $error("flash read answered while an operation ran");
   fetch_ok_a: assert property (rd_rsp.ready && rd_req.fetch && !rd_req.debug |-> !rd_rsp.fault)
      else $error("instruction fetch was faulted");
   fault_data_a: assert property (rd_rsp.fault |-> rd_rsp.ready && rd_rsp.rdata == 32'h0)
      else $error("faulted read carries data or no ready");
   dbg_block_a: assert property (rd_rsp.ready && rd_req.debug && !dap_enable |-> rd_rsp.fault)
      else $error("debugger read passed with debug access off");
   irq_level_a: assert property (acc && !pwrite && paddr == 12'h014 && !busy && !$past(busy, 2)
                                 |-> flash_irq == (prdata[1:0] != 2'h0))
      else $error("interrupt line differs from masked status");
   commit_busy_a: assert property (commit_wr |=> busy [*2])
      else $error("commit did not hold the sequencer busy");
   dap_stable_a: assert property (!$past(rst, 2) |-> $stable(dap_enable))
      else $error("debug access changed without power-on reset");
endmodule // fpc_ctrl_asserts

bind fpc_ctrl fpc_ctrl_asserts fpc_ctrl_asserts_i (
   .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
   .rd_valid(rd_valid), .rd_req(rd_req), .rd_rsp(rd_rsp), .flash_irq(flash_irq),
   .dap_enable(dap_enable), .busy(busy));

// ===== dv/fpc_master_model.sv
// flash read master standing for the core and the debugger
`timescale 1ns/1ps
module fpc_master_model
   import fpc_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire fpc_rd_rsp_t rd_rsp,
   output logic             rd_valid,
   output fpc_rd_req_t      rd_req
);
   initial
   begin
      rd_valid = 1'b0;
      rd_req   = '0;
   end

   // request held until ready is sampled high, then lines are turned over
   task automatic rd(input logic [13:0] a, input logic f, input logic dbg, input int gap,
                     output logic [31:0] d, output logic flt);
      repeat (gap + 1) @(posedge clk_sys);
      rd_valid <= 1'b1;
      rd_req   <= '{addr: a, fetch: f, debug: dbg};
      do @(posedge clk_sys); while (rd_rsp.ready !== 1'b1);
      d   = rd_rsp.rdata;
      flt = rd_rsp.fault;
      rd_valid <= 1'b0;
      rd_req   <= '{addr: ~a, fetch: ~f, debug: ~dbg};
   endtask
endmodule // fpc_master_model

// ===== dv/flash_protection_control_test.sv
// self-checking bench of the flash protection controller
`timescale 1ns/1ps
module flash_protection_control_test
   import fpc_pkg::*;
   ;
   logic        clk_sys, rst, rst_factory, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic        pready, pslverr, rd_valid, flash_irq, dap_enable, busy, err, flt;
   fpc_rd_req_t rd_req;
   fpc_rd_rsp_t rd_rsp;
   int          n_errors, num_checks, cycles;
   localparam logic [11:0] ROW_A [9] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010,
                                         12'h014, 12'h130, 12'h134, 12'h140};
   localparam logic [31:0] ROW_V [9] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
                                         32'hbfffffff, 32'hffffffff, 32'h31};
   localparam logic [31:0] REFUSE [3] = '{32'ha4420001, 32'ha4420002, 32'ha4420004};

   fpc_ctrl #(.PROG_US(2), .ERASE_US(2), .MASS_US(2), .COMMIT_US(2)) fpc_ctrl_i (
      .clk_sys(clk_sys), .rst(rst), .rst_factory(rst_factory), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rd_valid(rd_valid), .rd_req(rd_req),
      .rd_rsp(rd_rsp), .flash_irq(flash_irq), .dap_enable(dap_enable), .busy(busy));
   fpc_master_model fpc_master_model_i (.clk_sys(clk_sys), .rd_rsp(rd_rsp),
      .rd_valid(rd_valid), .rd_req(rd_req));

   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic report_and_stop;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rdv = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk($sformatf("register %h", a), rdv, e);
   endtask
   task automatic poll(input int b);
      do apb(1'b0, 12'h008, 32'h0); while (rdv[b] !== 1'b0);
   endtask
   task automatic fchk(input logic [13:0] a, input logic [1:0] kind, input int gap,
                       input logic [31:0] e, input logic ef);
      fpc_master_model_i.rd(a, kind[0], kind[1], gap, rdv, flt);
      chk("flash data", rdv, e);
      chk("flash fault", {31'h0, flt}, {31'h0, ef});
   endtask
   task automatic bit_chk(input string name, input logic s, input logic e);
      chk(name, {31'h0, s}, {31'h0, e});
   endtask

   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_errors++;
         report_and_stop();
      end
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      {rst, rst_factory, psel, penable, pwrite} = 5'b11000;
      {paddr, pwdata, n_errors, num_checks, cycles} = '0;
      repeat (12) @(posedge clk_sys);
      rst         <= 1'b0;
      rst_factory <= 1'b0;
      foreach (ROW_A[i]) rchk(ROW_A[i], ROW_V[i]);
      apb(1'b0, 12'h0fc, 32'h0);
      bit_chk("unmapped error", err, 1'b1);
      bit_chk("debug access", dap_enable, 1'b1);
      apb(1'b1, 12'h140, 32'h1);
      apb(1'b1, 12'h010, 32'h3);
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h008, 32'ha4420002);
      poll(1);
      rchk(12'h00c, 32'h2);
      bit_chk("irq", flash_irq, 1'b1);
      fchk(14'h0ff, 2'b00, 0, 32'hffffffff, 1'b0);
      apb(1'b1, 12'h014, 32'h0);
      rchk(12'h00c, 32'h2);
      apb(1'b1, 12'h014, 32'h2);
      rchk(12'h00c, 32'h0);
      bit_chk("irq", flash_irq, 1'b0);
      apb(1'b1, 12'h004, 32'hf0f0f0f0);
      apb(1'b1, 12'h000, 32'h4);
      apb(1'b1, 12'h008, 32'ha4420001);
      fchk(14'h001, 2'b00, 3, 32'hf0f0f0f0, 1'b0);
      apb(1'b1, 12'h004, 32'hff00ff00);
      apb(1'b1, 12'h008, 32'ha4420001);
      poll(0);
      fchk(14'h001, 2'b00, 0, 32'hf000f000, 1'b0);
      apb(1'b1, 12'h014, 32'h3);
      apb(1'b1, 12'h010, 32'h2);
      apb(1'b1, 12'h134, 32'hfffffffe);
      apb(1'b1, 12'h134, 32'hffffffff);
      rchk(12'h134, 32'hfffffffe);
      apb(1'b1, 12'h000, 32'h1);
      apb(1'b1, 12'h008, 32'ha4420008);
      poll(3);
      apb(1'b1, 12'h134, 32'hfffffffc);
      apb(1'b1, 12'h000, 32'h4);
      foreach (REFUSE[i])
      begin
         apb(1'b1, 12'h008, REFUSE[i]);
         rchk(12'h008, 32'h0);
      end
      rchk(12'h00c, 32'h1);
      bit_chk("irq masked", flash_irq, 1'b0);
      apb(1'b1, 12'h010, 32'h3);
      rchk(12'h014, 32'h1);
      bit_chk("irq", flash_irq, 1'b1);
      fchk(14'h001, 2'b00, 0, 32'hf000f000, 1'b0);
      apb(1'b1, 12'h130, 32'h3ffffffe);
      fchk(14'h001, 2'b00, 0, 32'h0, 1'b1);
      fchk(14'h001, 2'b01, 0, 32'hf000f000, 1'b0);
      fchk(14'h001, 2'b11, 2, 32'hf000f000, 1'b0);
      apb(1'b1, 12'h000, 32'h900);
      apb(1'b1, 12'h008, 32'ha4420008);
      poll(3);
      bit_chk("debug access", dap_enable, 1'b1);
      rst <= 1'b1;
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      rchk(12'h130, 32'h3ffffffe);
      rchk(12'h134, 32'hfffffffe);
      bit_chk("debug access", dap_enable, 1'b0);
      fchk(14'h001, 2'b11, 0, 32'h0, 1'b1);
      fchk(14'h001, 2'b01, 0, 32'hf000f000, 1'b0);
      fchk(14'h001, 2'b00, 0, 32'h0, 1'b1);
      report_and_stop();
   end
endmodule // flash_protection_control_test
